// File: pkg/i2c_mctl_pkg.sv
// Register map, field positions and reset values of the master control block.
// Function
// - With the complete enable set, a stop condition seen on the bus raises the interrupt.
// - With the NACK enable set, a not-acknowledge taken by the master raises the interrupt.
// - With the arbitration-lost enable set, losing the bus raises the interrupt.
// - With the transmit enable set, each byte the master sends raises the interrupt.
// - With the receive enable set, received data raises the interrupt; clearing it suppresses them.
// - Stretch set while SCL is low holds SCL low until stretch is cleared.
// - Stretch set while SCL is high waits for the next SCL fall, then holds SCL low until cleared.
// - Internal loopback feeds the driven SCL and SDA back to the block's own inputs.
// - With backoff disabled the master may start even while another device drives a start.
// - With backoff enabled the master defers a start until the bus is free.
// - The block acts as master only while master enable is set.
// - A status condition interrupts only if its enable is set when the condition is raised.
// - The master role drops one cycle after slave mode is entered and stays off while slave mode lasts.
package i2c_mctl_pkg;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h01ff;
	localparam int MEN_BIT = 0;
	localparam int BD_BIT = 1;
	localparam int ILEN_BIT = 2;
	localparam int MSEN_BIT = 3;
	localparam int RXEN_BIT = 4;
	localparam int TXEN_BIT = 5;
	localparam int ALEN_BIT = 6;
	localparam int NACKEN_BIT = 7;
	localparam int CEN_BIT = 8;
	localparam int ST_RX_BIT = 4;
	localparam int ST_TX_BIT = 5;
	localparam int ST_AL_BIT = 6;
	localparam int ST_NACK_BIT = 7;
	localparam int ST_DONE_BIT = 8;
	localparam int ST_BUSY_BIT = 10;
	localparam int ST_MACT_BIT = 11;
	localparam int ST_HOLD_BIT = 12;
	localparam int NSRC = 5;
endpackage

// File: pkg/i2c_lines_if.sv
// Synchronised SCL and SDA levels passed from the pin synchroniser to the control logic.
interface i2c_lines_if;
	logic scl;
	logic sda;
	modport src (output scl, output sda);
	modport dst (input scl, input sda);
endinterface

// File: hdl/i2c_pin_sync.sv
// Two-flop synchroniser for the SCL and SDA pad inputs.
module i2c_pin_sync (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Pad levels.
	input wire logic scl_pad,
	input wire logic sda_pad,
	// Synchronised levels.
	i2c_lines_if.src lines
);
	logic [1:0] meta_q;
	logic [1:0] sync_q;

	// The first stage feeds only the second stage; lines idle high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
		end else begin
			meta_q <= {scl_pad, sda_pad};
			sync_q <= meta_q;
		end
	end

	assign lines.scl = sync_q[1];
	assign lines.sda = sync_q[0];
endmodule

// File: hdl/irq_source.sv
// One interrupt source: pends on a rising condition only while enabled.
module irq_source (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Condition level and its enable.
	input wire logic cond,
	input wire logic enable,
	// Pending output.
	output logic pend
);
	logic cond_q;
	logic pend_q;

	// Pend on the rising condition if enabled then; drop when the condition or enable goes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			cond_q <= cond;
			if (!cond || !enable) begin
				pend_q <= 1'b0;
			end else if (!cond_q) begin
				pend_q <= 1'b1;
			end
		end
	end

	assign pend = pend_q;
endmodule

// File: hdl/i2c_master_control.sv
// Master control register, stretch, loopback, backoff and interrupt gating of the I2C channel.
//
// Design decisions made here: the register offsets and the APB slave port.
module i2c_master_control (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Open-drain pins.
	input wire logic scl_pad,
	input wire logic sda_pad,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	// Master engine side.
	input wire logic core_scl_low,
	input wire logic core_sda_low,
	input wire logic nack_stat,
	input wire logic arb_lost_stat,
	input wire logic tx_done_stat,
	input wire logic rx_data_stat,
	input wire logic slave_mode,
	output logic scl_seen,
	output logic sda_seen,
	output logic master_active,
	output logic start_permit,
	output logic bus_busy,
	// Interrupt.
	output logic irq
);
	i2c_lines_if lines ();
	logic [15:0] ctrl_q;
	logic [15:0] stat_rd;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wr_en;
	logic rd_ctrl;
	logic rd_stat;
	logic scl_v;
	logic sda_v;
	logic scl_prev_q;
	logic sda_prev_q;
	logic start_det;
	logic stop_det;
	logic busy_q;
	logic done_q;
	logic hold_q;
	logic mact_q;
	logic permit_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic scl_seen_q;
	logic sda_seen_q;
	logic irq_q;
	logic drv_scl;
	logic drv_sda;
	logic [i2c_mctl_pkg::NSRC-1:0] cond;
	logic [i2c_mctl_pkg::NSRC-1:0] en;
	logic [i2c_mctl_pkg::NSRC-1:0] pend;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser.
	i2c_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.scl_pad(scl_pad),
		.sda_pad(sda_pad),
		.lines(lines.src)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode: access phase completes on the cycle pready is high.
	assign wr_en = psel && penable && pready_q && pwrite;
	assign rd_ctrl = paddr == i2c_mctl_pkg::CTRL_OFF;
	assign rd_stat = paddr == i2c_mctl_pkg::STAT_OFF;

	// Pready rises in the first access cycle, so every transfer takes no wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !rd_ctrl && !rd_stat;
		end
	end

	// Read data is captured in the setup cycle; unmapped addresses read zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			if (rd_ctrl) begin
				prdata_q <= {16'h0000, ctrl_q};
			end else if (rd_stat) begin
				prdata_q <= {16'h0000, stat_rd};
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Control register; reserved upper bits are never stored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= i2c_mctl_pkg::CTRL_RESET;
		end else if (wr_en && rd_ctrl) begin
			ctrl_q <= pwdata[15:0] & i2c_mctl_pkg::CTRL_WMASK;
		end
	end

	// Status read view.
	always_comb begin
		stat_rd = 16'h0000;
		stat_rd[i2c_mctl_pkg::ST_RX_BIT] = rx_data_stat;
		stat_rd[i2c_mctl_pkg::ST_TX_BIT] = tx_done_stat;
		stat_rd[i2c_mctl_pkg::ST_AL_BIT] = arb_lost_stat;
		stat_rd[i2c_mctl_pkg::ST_NACK_BIT] = nack_stat;
		stat_rd[i2c_mctl_pkg::ST_DONE_BIT] = done_q;
		stat_rd[i2c_mctl_pkg::ST_BUSY_BIT] = busy_q;
		stat_rd[i2c_mctl_pkg::ST_MACT_BIT] = mact_q;
		stat_rd[i2c_mctl_pkg::ST_HOLD_BIT] = hold_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Line view: in loopback the driven levels replace the pads.
	assign drv_scl = mact_q && (core_scl_low || hold_q);
	assign drv_sda = mact_q && core_sda_low;
	assign scl_v = ctrl_q[i2c_mctl_pkg::ILEN_BIT] ? !drv_scl : lines.scl;
	assign sda_v = ctrl_q[i2c_mctl_pkg::ILEN_BIT] ? !drv_sda : lines.sda;
	assign start_det = sda_prev_q && !sda_v && scl_prev_q && scl_v;
	assign stop_det = !sda_prev_q && sda_v && scl_prev_q && scl_v;

	// Previous line levels for edge detection, and levels shown to the engine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			scl_seen_q <= 1'b1;
			sda_seen_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_v;
			sda_prev_q <= sda_v;
			scl_seen_q <= scl_v;
			sda_seen_q <= sda_v;
		end
	end

	// Bus busy from start to stop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1;
		end else if (stop_det) begin
			busy_q <= 1'b0;
		end
	end

	// Transmission complete flag: set by a stop, cleared by writing one; the set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (stop_det) begin
			done_q <= 1'b1;
		end else if (wr_en && rd_stat && pwdata[i2c_mctl_pkg::ST_DONE_BIT]) begin
			done_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Master role and start permission.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mact_q <= 1'b0;
			permit_q <= 1'b0;
		end else begin
			mact_q <= ctrl_q[i2c_mctl_pkg::MEN_BIT] && !slave_mode;
			permit_q <= mact_q && (ctrl_q[i2c_mctl_pkg::BD_BIT] || !busy_q);
		end
	end

	// Stretch: hold at once if SCL is low, else from the next fall; release when cleared.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 1'b0;
		end else begin
			hold_q <= mact_q && ctrl_q[i2c_mctl_pkg::MSEN_BIT] && (hold_q || !scl_v);
		end
	end

	// Pin drivers: open drain, off in loopback.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_oe_q <= drv_scl && !ctrl_q[i2c_mctl_pkg::ILEN_BIT];
			sda_oe_q <= drv_sda && !ctrl_q[i2c_mctl_pkg::ILEN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt sources, in order: receive, transmit, arbitration, NACK, complete.
	assign cond = {done_q, nack_stat, arb_lost_stat, tx_done_stat, rx_data_stat};
	assign en = ctrl_q[i2c_mctl_pkg::CEN_BIT:i2c_mctl_pkg::RXEN_BIT];

	for (genvar i = 0; i < i2c_mctl_pkg::NSRC; i++) begin : g_src
		irq_source u_src (
			.pclk(pclk),
			.presetn(presetn),
			.cond(cond[i]),
			.enable(en[i]),
			.pend(pend[i])
		);
	end

	// Interrupt output is the OR of pending sources.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output assignments.
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign scl_seen = scl_seen_q;
	assign sda_seen = sda_seen_q;
	assign master_active = mact_q;
	assign start_permit = permit_q;
	assign bus_busy = busy_q;
	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_reserved_zero: assert property (wr_en && rd_ctrl |=> ctrl_q[15:9] == 7'h00)
		else $error("reserved control bits stored");
	a_stop_irq_raise: assert property (stop_det && !done_q && en[4] ##1 en[4] |-> ##[1:2] irq_q)
		else $error("stop did not raise interrupt");
	a_nack_irq_raise: assert property ($rose(nack_stat) && en[3] ##1 nack_stat && en[3] |=> irq_q)
		else $error("nack did not raise interrupt");
	a_arb_irq_raise: assert property ($rose(arb_lost_stat) && en[2] ##1 arb_lost_stat && en[2] |=> irq_q)
		else $error("arbitration loss did not raise interrupt");
	a_tx_irq_raise: assert property ($rose(tx_done_stat) && en[1] ##1 tx_done_stat && en[1] |=> irq_q)
		else $error("byte sent did not raise interrupt");
	a_rx_irq_mask: assert property (!en[0] |=> !pend[0])
		else $error("receive interrupt not suppressed");
	a_stretch_low_hold: assert property (mact_q && ctrl_q[3] && !scl_v |=> hold_q)
		else $error("stretch did not hold low scl");
	a_stretch_high_wait: assert property (!hold_q && scl_v |=> !hold_q)
		else $error("stretch held before scl fell");
	a_stretch_keep: assert property (hold_q && mact_q && ctrl_q[3] |=> hold_q)
		else $error("stretch released while enabled");
	a_loop_no_drive: assert property (ctrl_q[2] |=> !scl_oe_q && !sda_oe_q)
		else $error("pins driven in loopback");
	a_backoff_defer: assert property (busy_q && !ctrl_q[1] |=> !permit_q)
		else $error("start permitted on busy bus");
	a_nobackoff_go: assert property (mact_q && ctrl_q[1] |=> permit_q)
		else $error("start withheld with backoff disabled");
	a_master_off: assert property (!ctrl_q[0] || slave_mode |=> !mact_q)
		else $error("master active while disabled or slave");
	a_late_enable: assert property (cond[3] && !en[3] ##1 cond[3] && en[3] |=> !pend[3])
		else $error("late enable raised interrupt");
	a_irq_or: assert property (irq_q == $past(|pend))
		else $error("interrupt not the OR of pending sources");

	////////////////////////////////////////////////////////////////////////////
	// Register interface checks.
	a_reserved_read: assert property (psel && !penable && rd_ctrl |=> prdata_q[31:9] == 23'h000000)
		else $error("reserved control bits read back set");
	a_ctrl_steady: assert property (!(wr_en && rd_ctrl) |=> $stable(ctrl_q))
		else $error("control register changed without a write");
	a_enable_take: assert property (
		wr_en && rd_ctrl && pwdata[i2c_mctl_pkg::MEN_BIT] ##1 !slave_mode |=> mact_q)
		else $error("master enable not taken");

	////////////////////////////////////////////////////////////////////////////
	// Interrupt source checks.
	a_nack_pend: assert property ($rose(cond[3]) && en[3] |=> pend[3])
		else $error("nack source did not pend");
	a_arb_pend: assert property ($rose(cond[2]) && en[2] |=> pend[2])
		else $error("arbitration source did not pend");
	a_tx_pend: assert property ($rose(cond[1]) && en[1] |=> pend[1])
		else $error("transmit source did not pend");
	a_rx_pend: assert property ($rose(cond[0]) && en[0] |=> pend[0])
		else $error("receive source did not pend");
	a_done_pend: assert property ($rose(cond[4]) && en[4] |=> pend[4])
		else $error("completion source did not pend");
	a_pend_qualified: assert property (pend == (pend & $past(cond) & $past(en)))
		else $error("source pending without condition and enable");
	a_irq_cleared: assert property (pend == 5'h00 |=> !irq_q)
		else $error("interrupt held with nothing pending");
	a_done_clear: assert property (
		!stop_det && wr_en && rd_stat && pwdata[i2c_mctl_pkg::ST_DONE_BIT] |=> !done_q)
		else $error("completion flag not cleared");

	////////////////////////////////////////////////////////////////////////////
	// Line, bus-state and drive checks.
	a_done_set: assert property (stop_det |=> done_q)
		else $error("stop did not set completion flag");
	a_busy_start: assert property (start_det |=> busy_q)
		else $error("start did not mark bus busy");
	a_busy_stop: assert property (stop_det |=> !busy_q)
		else $error("stop did not free the bus");
	a_backoff_free: assert property (mact_q && !busy_q |=> permit_q)
		else $error("start withheld on free bus");
	a_permit_master: assert property (!mact_q |=> !permit_q)
		else $error("start permitted outside master mode");
	a_master_drive: assert property (!mact_q |=> !scl_oe_q && !sda_oe_q)
		else $error("pins driven outside master mode");
	a_stretch_gate: assert property (!mact_q |=> !hold_q)
		else $error("stretch held outside master mode");
	a_hold_fall: assert property ($rose(hold_q) |-> $past(!scl_v))
		else $error("stretch began while scl high");
	a_hold_release: assert property (!ctrl_q[i2c_mctl_pkg::MSEN_BIT] |=> !hold_q)
		else $error("stretch kept after disable");
	a_hold_drive: assert property (hold_q && mact_q && !ctrl_q[i2c_mctl_pkg::ILEN_BIT] |=> scl_oe_q)
		else $error("stretch did not pull scl low");
	a_slave_release: assert property (slave_mode |-> ##2 !scl_oe_q && !sda_oe_q)
		else $error("pins driven in slave mode");
	a_loop_seen: assert property (ctrl_q[i2c_mctl_pkg::ILEN_BIT] && !drv_scl |=> scl_seen_q)
		else $error("loopback scl not seen high");
	a_loop_sda: assert property (ctrl_q[i2c_mctl_pkg::ILEN_BIT] && !drv_sda |=> sda_seen_q)
		else $error("loopback sda not seen high");

	////////////////////////////////////////////////////////////////////////////
	// Scenario covers.
	c_stop_irq: cover property (stop_det ##[1:3] irq_q);
	c_stretch: cover property (ctrl_q[3] && scl_v ##[1:20] hold_q);
	c_loopback: cover property (ctrl_q[2] && drv_scl);
	c_backoff: cover property (busy_q && ctrl_q[1] && permit_q);
	c_late_enable: cover property (cond[3] && !en[3] ##1 cond[3] && en[3]);
endmodule

// File: testbench/i2c_far_side.sv
// Behavioural far side of the I2C link: another master or slave sharing SCL and SDA.
module i2c_far_side (
	// Pin drives of the block.
	input wire logic scl_oe,
	input wire logic sda_oe,
	// Wired-AND line levels.
	output logic scl_pad,
	output logic sda_pad
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_low = 1'h0;
	logic sda_low = 1'h0;
	////////////////////////////////////////////////////////////////////////
	// The pull-ups win unless some party pulls a line low.
	assign scl_pad = !(scl_oe | scl_low);
	assign sda_pad = !(sda_oe | sda_low);
	// Holds SCL at one level for half a link period; levels change after the edge so the synchroniser never races them.
	task automatic scl_drive(input logic v);
		scl_low <= v;
		#100;
	endtask
	// SDA falls while SCL is high, then SCL is taken low.
	task automatic start_cond();
		sda_low <= 1'h1;
		#100;
		scl_drive(1'h1);
	endtask
	// SCL is released first, then SDA rises while SCL is high.
	task automatic stop_cond();
		sda_low <= 1'h1;
		scl_drive(1'h0);
		sda_low <= 1'h0;
		#100;
	endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the I2C master control block.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] CTL = i2c_mctl_pkg::CTRL_OFF;
	localparam logic [11:0] STA = i2c_mctl_pkg::STAT_OFF;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, scl_pad, sda_pad, scl_out, scl_oe, sda_out, sda_oe, ev;
	logic core_scl_low = 1'h0, core_sda_low = 1'h0, slave_mode = 1'h0;
	logic [3:0] st = 4'h0;
	logic scl_seen, sda_seen, master_active, start_permit, bus_busy, irq;
	int failures = 0, n_compared = 0;
	////////////////////////////////////////////////////////////////////////
	// The clock toggles every 12.5 ns, a period of 25 ns.
	always #12.5 pclk = ~pclk;
	// Design and far side.
	i2c_master_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .scl_pad, .sda_pad, .scl_out, .scl_oe, .sda_out, .sda_oe, .core_scl_low, .core_sda_low,
		.nack_stat(st[3]), .arb_lost_stat(st[2]), .tx_done_stat(st[1]), .rx_data_stat(st[0]), .slave_mode,
		.scl_seen, .sda_seen, .master_active, .start_permit, .bus_busy, .irq);
	i2c_far_side far (.scl_oe, .sda_oe, .scl_pad, .sda_pad);
	////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic report_and_stop();
		if (failures == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	// Lets n rising edges pass.
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rv = prdata;
		ev = pslverr;
		{psel, penable} <= 2'h0;
		if (n >= 20) begin
			failures++;
			report_and_stop();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Register reset value, writable field and an unmapped address.
	task automatic t_regs();
		apb(1'h0, CTL, 32'h0);
		chk("ctrl reset", 32'h0, rv);
		apb(1'h1, CTL, 32'h1ff);
		apb(1'h0, CTL, 32'h0);
		chk("ctrl fields", 32'h1ff, rv);
		apb(1'h0, 12'h008, 32'h0);
		chk("unmapped err", 32'h1, ev);
		chk("unmapped data", 32'h0, rv);
		apb(1'h1, CTL, 32'h0);
	endtask
	// Each engine status against its enable.
	task automatic t_irq();
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, CTL, 32'h10 << i);
			@(posedge pclk) st[i] <= 1'h1;
			wt(4);
			chk("irq on", 32'h1, irq);
			apb(1'h1, CTL, 32'h0);
			wt(4);
			chk("irq enable cleared", 32'h0, irq);
			@(posedge pclk) st[i] <= 1'h0;
			wt(2);
			@(posedge pclk) st[i] <= 1'h1;
			wt(4);
			chk("irq masked", 32'h0, irq);
			apb(1'h1, CTL, 32'h10 << i);
			wt(4);
			chk("irq late enable", 32'h0, irq);
			@(posedge pclk) st[i] <= 1'h0;
			wt(4);
			chk("irq cond gone", 32'h0, irq);
		end
		apb(1'h1, CTL, 32'h0);
	endtask
	// Start and stop from the far side, backoff and completion.
	task automatic t_stop();
		apb(1'h1, CTL, 32'h101);
		far.start_cond();
		wt(4);
		chk("busy after start", 32'h1, bus_busy);
		chk("permit backing off", 32'h0, start_permit);
		apb(1'h1, CTL, 32'h103);
		wt(3);
		chk("permit no backoff", 32'h1, start_permit);
		far.stop_cond();
		wt(6);
		chk("busy after stop", 32'h0, bus_busy);
		chk("complete irq", 32'h1, irq);
		apb(1'h0, STA, 32'h0);
		chk("complete flag", 32'h1, rv[i2c_mctl_pkg::ST_DONE_BIT]);
		chk("status master", 32'h1, rv[i2c_mctl_pkg::ST_MACT_BIT]);
		chk("status bus free", 32'h0, rv[i2c_mctl_pkg::ST_BUSY_BIT]);
		apb(1'h1, STA, 32'h100);
		wt(4);
		chk("complete cleared", 32'h0, irq);
		apb(1'h1, CTL, 32'h1);
		wt(3);
		chk("permit bus free", 32'h1, start_permit);
	endtask
	// Stretch set with SCL low and with SCL high.
	task automatic t_stretch();
		far.scl_drive(1'h1);
		apb(1'h1, CTL, 32'h9);
		wt(3);
		far.scl_drive(1'h0);
		wt(4);
		chk("stretch holds", 32'h1, scl_oe);
		chk("scl line low", 32'h0, scl_pad);
		apb(1'h1, CTL, 32'h1);
		wt(3);
		chk("stretch off", 32'h0, scl_oe);
		apb(1'h1, CTL, 32'h9);
		wt(4);
		chk("wait for fall", 32'h0, scl_oe);
		far.scl_drive(1'h1);
		far.scl_drive(1'h0);
		wt(4);
		chk("hold after fall", 32'h1, scl_oe);
		apb(1'h0, STA, 32'h0);
		chk("status holding", 32'h1, rv[i2c_mctl_pkg::ST_HOLD_BIT]);
		apb(1'h1, CTL, 32'h1);
		wt(3);
	endtask
	// Engine drives, loopback and the master role.
	task automatic t_loop();
		@(posedge pclk) {core_scl_low, core_sda_low} <= 2'h3;
		wt(4);
		chk("drive scl", 32'h1, scl_oe);
		chk("drive sda", 32'h1, sda_oe);
		chk("sda line low", 32'h0, sda_pad);
		chk("open drain levels", 32'h0, {scl_out, sda_out});
		apb(1'h1, CTL, 32'h5);
		wt(4);
		chk("loop pins", 32'h0, {scl_oe, sda_oe});
		chk("loop seen", 32'h0, {scl_seen, sda_seen});
		@(posedge pclk) {core_scl_low, core_sda_low} <= 2'h0;
		wt(4);
		chk("loop seen high", 32'h3, {scl_seen, sda_seen});
		apb(1'h1, CTL, 32'h0);
		@(posedge pclk) core_scl_low <= 1'h1;
		wt(4);
		chk("idle no drive", 32'h0, scl_oe);
		chk("master off", 32'h0, master_active);
		apb(1'h1, CTL, 32'h1);
		wt(3);
		chk("master on", 32'h1, master_active);
		@(posedge pclk) slave_mode <= 1'h1;
		wt(4);
		chk("slave blocks", 32'h0, master_active);
		chk("slave no drive", 32'h0, scl_oe);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Reset for 16 cycles, then every scenario in turn.
	initial begin
		wt(16);
		presetn <= 1'h1;
		t_regs();
		t_irq();
		t_stop();
		t_stretch();
		t_loop();
		report_and_stop();
	end
endmodule
